//--- hdl/swkt_top.sv
// Purpose: self-launching 32-bit wake-up down counter with register port
// Assumes: single system clock; internal sources are tick enables made from clk, the pin is synchronised into ticks
// Notes: reads return data one cycle after the read strobe
//
// Design decision made here: the strobed register port.

// Functional notes
// R01: a 32-bit down counter starts once software loads a non-zero value.
// R02: at zero it raises timeout and wake request, then stops until reloaded.
// R03: control bit 0 picks 750 kHz fast source (default 0) or 1 MHz source.
// R04: the internal select bit is ignored while the external select is set.
// R05: control bit 3 picks internal source or the external clock pin.
// R06: control bit 1 is the timeout flag, write one clears, zero no effect.
// R07: the flag's wake request works in any mode where the source still runs.
// R08: writing 1 to control bit 2 clears and halts the counter; reads zero.
// R09: count register at 0xc loads and launches; reads give present value.
// R10: software must not write the count while counting is in progress.
// R11: software should read the count twice, since bits may change mid-read.
// R12: software must not use the fast source to wake from deep sleep modes.
// R13: software must enable the low-power oscillator before selecting it.
// R14: register actions and timer ticks meet safely in one clock domain.
module swkt_top (
    input wire logic clk,
    input wire logic rst,
    input wire logic [swkt_pkg::ADDR_W-1:0] addr,
    input wire logic [swkt_pkg::DATA_W-1:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [swkt_pkg::DATA_W-1:0] rdata,
    input wire logic wake_clock_input_pin,
    output logic irq,
    output logic wake_req
);
    logic fast_tick;
    logic low_tick;
    logic ext_tick;
    logic timer_tick;

    logic internal_source_select_r;
    logic external_source_select_r;
    logic timeout_flag_r;
    logic running_r;
    logic [swkt_pkg::DATA_W-1:0] count_r;
    logic [swkt_pkg::EVT_W-1:0] status_r;
    logic [swkt_pkg::EVT_W-1:0] mask_r;

    logic wr_ctrl;
    logic wr_count;
    logic rd_status;
    logic counter_clear;
    logic load_go;
    logic timeout_evt;
    logic [swkt_pkg::EVT_W-1:0] events;

    swkt_tick_gen u_tick (
        .clk(clk),
        .rst(rst),
        .fast_tick(fast_tick),
        .low_tick(low_tick)
    );

    // the pin is foreign to clk, so it passes a two-stage synchroniser
    swkt_ext_sync u_ext (
        .clk(clk),
        .rst(rst),
        .pin(wake_clock_input_pin),
        .tick(ext_tick)
    ); // R14

    always_comb begin
        if (external_source_select_r) begin
            timer_tick = ext_tick; // R04 R05
        end else if (internal_source_select_r) begin
            timer_tick = low_tick; // R03
        end else begin
            timer_tick = fast_tick; // R03
        end
    end

    assign wr_ctrl = wr_en && (addr == swkt_pkg::OFF_CTRL);
    assign wr_count = wr_en && (addr == swkt_pkg::OFF_COUNT);
    assign rd_status = rd_en && (addr == swkt_pkg::OFF_STATUS);
    assign counter_clear = wr_ctrl && wdata[swkt_pkg::CTRL_CLEAR_BIT];
    assign load_go = wr_count && (wdata != '0);
    // tick on the last count: the counter lands on zero this cycle
    assign timeout_evt = running_r && timer_tick && (count_r == 32'h0000_0001);

    always_comb begin
        events = '0;
        events[swkt_pkg::EVT_TIMEOUT_BIT] = timeout_evt;
        events[swkt_pkg::EVT_LOAD_BUSY_BIT] = wr_count && running_r;
    end

    // source selection bits
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            internal_source_select_r <= swkt_pkg::CTRL_RESET[swkt_pkg::CTRL_INT_SEL_BIT];
            external_source_select_r <= swkt_pkg::CTRL_RESET[swkt_pkg::CTRL_EXT_SEL_BIT];
        end else if (wr_ctrl) begin
            internal_source_select_r <= wdata[swkt_pkg::CTRL_INT_SEL_BIT]; // R03
            external_source_select_r <= wdata[swkt_pkg::CTRL_EXT_SEL_BIT]; // R05
        end
    end

    // counter and run state; loads and clears share the bus cycle with ticks
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count_r <= swkt_pkg::COUNT_RESET;
            running_r <= 1'b0;
        end else if (counter_clear) begin
            count_r <= '0; // R08
            running_r <= 1'b0; // R08
        end else if (wr_count) begin
            count_r <= wdata; // R09
            running_r <= load_go; // R01
        end else if (running_r && timer_tick) begin
            count_r <= count_r - 32'h0000_0001; // R01
            if (count_r == 32'h0000_0001) begin
                running_r <= 1'b0; // R02
            end
        end
    end

    // timeout flag: a timeout in the clearing cycle still sets it
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            timeout_flag_r <= 1'b0;
        end else if (timeout_evt) begin
            timeout_flag_r <= 1'b1; // R02 R06
        end else if (wr_ctrl && wdata[swkt_pkg::CTRL_FLAG_BIT]) begin
            timeout_flag_r <= 1'b0; // R06
        end
    end

    // sticky event status, cleared by reading it; new events win
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            status_r <= swkt_pkg::EVT_RESET;
        end else if (rd_status) begin
            status_r <= events;
        end else begin
            status_r <= status_r | events;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mask_r <= swkt_pkg::EVT_RESET;
        end else if (wr_en && addr == swkt_pkg::OFF_MASK) begin
            mask_r <= wdata[swkt_pkg::EVT_W-1:0];
        end
    end

    // wake follows the flag alone so it needs no bus clock decode in sleep
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq <= 1'b0;
            wake_req <= 1'b0;
        end else begin
            irq <= |(status_r & mask_r);
            wake_req <= timeout_flag_r; // R07
        end
    end

    // read data stand only in the cycle after the strobe
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata <= '0;
        end else if (rd_en) begin
            unique case (addr)
                swkt_pkg::OFF_CTRL: begin
                    rdata <= {28'h0000000, external_source_select_r, 1'b0,
                              timeout_flag_r, internal_source_select_r}; // R08
                end
                swkt_pkg::OFF_COUNT: rdata <= count_r; // R09
                swkt_pkg::OFF_STATUS: rdata <= {30'h0, status_r};
                swkt_pkg::OFF_MASK: rdata <= {30'h0, mask_r};
                default: rdata <= '0;
            endcase
        end else begin
            rdata <= '0;
        end
    end

    sequence s_last_tick;
        running_r && timer_tick && count_r == 32'h0000_0001 && !wr_en;
    endsequence

    sequence s_expired;
        timeout_flag_r && !running_r && count_r == 32'h0000_0000;
    endsequence

    property p_load_starts;
        @(posedge clk) disable iff (rst)
        load_go |=> running_r && count_r == $past(wdata);
    endproperty
    a_load_starts: assert property (p_load_starts) else $error("load did not start"); // R01

    property p_timeout;
        @(posedge clk) disable iff (rst)
        s_last_tick |=> s_expired ##1 wake_req;
    endproperty
    a_timeout: assert property (p_timeout) else $error("timeout sequence wrong"); // R02

    property p_stays_idle;
        @(posedge clk) disable iff (rst)
        !running_r && !load_go |=> !running_r && $stable(count_r) || $past(counter_clear);
    endproperty
    a_stays_idle: assert property (p_stays_idle) else $error("idle counter moved"); // R02

    property p_src_ext;
        @(posedge clk) disable iff (rst)
        external_source_select_r |-> timer_tick == ext_tick;
    endproperty
    a_src_ext: assert property (p_src_ext) else $error("external source ignored"); // R04

    property p_src_int;
        @(posedge clk) disable iff (rst)
        !external_source_select_r |->
            timer_tick == (internal_source_select_r ? low_tick : fast_tick);
    endproperty
    a_src_int: assert property (p_src_int) else $error("internal source wrong"); // R03

    property p_flag_clear;
        @(posedge clk) disable iff (rst)
        wr_ctrl && wdata[swkt_pkg::CTRL_FLAG_BIT] && !timeout_evt |=> !timeout_flag_r;
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared"); // R06

    property p_flag_keep;
        @(posedge clk) disable iff (rst)
        timeout_flag_r && !(wr_ctrl && wdata[swkt_pkg::CTRL_FLAG_BIT]) |=> timeout_flag_r;
    endproperty
    a_flag_keep: assert property (p_flag_keep) else $error("flag lost"); // R06

    property p_clear;
        @(posedge clk) disable iff (rst)
        counter_clear |=> count_r == 32'h0000_0000 && !running_r;
    endproperty
    a_clear: assert property (p_clear) else $error("clear did not halt"); // R08

    property p_clear_reads0;
        @(posedge clk) disable iff (rst)
        rd_en && addr == swkt_pkg::OFF_CTRL |=> rdata[swkt_pkg::CTRL_CLEAR_BIT] == 1'b0;
    endproperty
    a_clear_reads0: assert property (p_clear_reads0) else $error("clear bit read 1"); // R08

    property p_read_count;
        @(posedge clk) disable iff (rst)
        rd_en && addr == swkt_pkg::OFF_COUNT |=> rdata == $past(count_r);
    endproperty
    a_read_count: assert property (p_read_count) else $error("count read wrong"); // R09

    property p_wake;
        @(posedge clk) disable iff (rst)
        timeout_flag_r |=> wake_req;
    endproperty
    a_wake: assert property (p_wake) else $error("wake not raised"); // R07

    sequence s_step;
        running_r && timer_tick && !wr_en;
    endsequence

    // fast source averages 750 kHz: one tick every 133 or 134 cycles
    property p_fast_rate;
        @(posedge clk) disable iff (rst)
        fast_tick |=> !fast_tick ##[132:133] fast_tick;
    endproperty
    a_fast_rate: assert property (p_fast_rate) else $error("fast tick rate wrong"); // R03

    property p_low_rate;
        @(posedge clk) disable iff (rst)
        low_tick |=> !low_tick ##99 low_tick;
    endproperty
    a_low_rate: assert property (p_low_rate) else $error("low tick rate wrong"); // R03

    // a long pin level must still give a single count
    property p_ext_pulse;
        @(posedge clk) disable iff (rst)
        ext_tick |=> !ext_tick;
    endproperty
    a_ext_pulse: assert property (p_ext_pulse) else $error("pin tick too long"); // R05

    property p_count_step;
        @(posedge clk) disable iff (rst)
        s_step |=> count_r == $past(count_r) - 32'h0000_0001;
    endproperty
    a_count_step: assert property (p_count_step) else $error("count did not step"); // R01

    property p_count_hold;
        @(posedge clk) disable iff (rst)
        running_r && !timer_tick && !wr_en |=> running_r && $stable(count_r);
    endproperty
    a_count_hold: assert property (p_count_hold) else $error("count moved without tick"); // R01

    property p_zero_load;
        @(posedge clk) disable iff (rst)
        wr_count && wdata == 32'h0000_0000 |=> !running_r && count_r == 32'h0000_0000;
    endproperty
    a_zero_load: assert property (p_zero_load) else $error("zero load started"); // R01

    property p_status_timeout;
        @(posedge clk) disable iff (rst)
        timeout_evt |=> status_r[swkt_pkg::EVT_TIMEOUT_BIT];
    endproperty
    a_status_timeout: assert property (p_status_timeout) else $error("timeout not logged"); // R02

    property p_busy;
        @(posedge clk) disable iff (rst)
        wr_count && running_r |=> status_r[swkt_pkg::EVT_LOAD_BUSY_BIT];
    endproperty
    a_busy: assert property (p_busy) else $error("busy write not logged"); // R09

    property p_irq_high;
        @(posedge clk) disable iff (rst)
        (status_r & mask_r) != 2'h0 |=> irq;
    endproperty
    a_irq_high: assert property (p_irq_high) else $error("irq missing"); // R02

    property p_irq_low;
        @(posedge clk) disable iff (rst)
        (status_r & mask_r) == 2'h0 |=> !irq;
    endproperty
    a_irq_low: assert property (p_irq_low) else $error("irq without event"); // R02

    property p_rdata_idle;
        @(posedge clk) disable iff (rst)
        !rd_en |=> rdata == 32'h0000_0000;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data stood too long"); // R09
endmodule

//--- hdl/swkt_pkg.sv
// Purpose: shared constants for the self-wake down counter
// Assumes: 100 MHz system clock, byte addresses on the register port
// Notes: timer sources are modelled as one-cycle tick enables
package swkt_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_COUNT = 8'h0c;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_MASK = 8'h14;

    // control register fields
    localparam int CTRL_INT_SEL_BIT = 0;
    localparam int CTRL_FLAG_BIT = 1;
    localparam int CTRL_CLEAR_BIT = 2;
    localparam int CTRL_EXT_SEL_BIT = 3;

    // event status / mask fields
    localparam int EVT_W = 2;
    localparam int EVT_TIMEOUT_BIT = 0;
    localparam int EVT_LOAD_BUSY_BIT = 1;

    localparam logic [DATA_W-1:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [DATA_W-1:0] COUNT_RESET = 32'h0000_0000;
    localparam logic [EVT_W-1:0] EVT_RESET = 2'h0;

    // rates in hertz
    localparam int CLK_HZ = 100_000_000;
    localparam int FAST_OSC_HZ = 750_000;
    localparam int LOW_OSC_HZ = 1_000_000;

    // low-power tick: integer divide
    localparam int LOW_DIV = CLK_HZ / LOW_OSC_HZ;
    // fast tick: fractional accumulator, step / modulus = 750 kHz / 100 MHz
    localparam int FRAC_UNIT = 250_000;
    localparam int FAST_STEP = FAST_OSC_HZ / FRAC_UNIT;
    localparam int FAST_MOD = CLK_HZ / FRAC_UNIT;
    localparam int DIV_W = 9;
endpackage

//--- hdl/swkt_ext_sync.sv
// Purpose: bring the external timer clock pin into the system clock
// Assumes: pin is asynchronous and much slower than clk
// Notes: emits a one-cycle tick per rising edge of the pin
module swkt_ext_sync (
    input wire logic clk,
    input wire logic rst,
    input wire logic pin,
    output logic tick
);
    logic meta_r;
    logic sync_r;
    logic prev_r;

    // first stage feeds only the second; the edge compare uses later stages
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
            prev_r <= 1'b0;
        end else begin
            meta_r <= pin;
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tick <= 1'b0;
        end else begin
            tick <= sync_r & ~prev_r;
        end
    end
endmodule

//--- hdl/swkt_tick_gen.sv
// Purpose: derive the two internal timer tick enables from clk
// Assumes: clk at swkt_pkg::CLK_HZ
// Notes: the fast tick averages 750 kHz exactly, with jitter of one clk
module swkt_tick_gen (
    input wire logic clk,
    input wire logic rst,
    output logic fast_tick,
    output logic low_tick
);
    localparam logic [swkt_pkg::DIV_W-1:0] STEP = swkt_pkg::DIV_W'(swkt_pkg::FAST_STEP);
    localparam logic [swkt_pkg::DIV_W-1:0] MODV = swkt_pkg::DIV_W'(swkt_pkg::FAST_MOD);
    localparam logic [swkt_pkg::DIV_W-1:0] LOWV = swkt_pkg::DIV_W'(swkt_pkg::LOW_DIV - 1);

    logic [swkt_pkg::DIV_W-1:0] acc_r;
    logic [swkt_pkg::DIV_W-1:0] low_cnt_r;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            acc_r <= '0;
            fast_tick <= 1'b0;
        end else if (acc_r + STEP >= MODV) begin
            acc_r <= acc_r + STEP - MODV;
            fast_tick <= 1'b1;
        end else begin
            acc_r <= acc_r + STEP;
            fast_tick <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            low_cnt_r <= '0;
            low_tick <= 1'b0;
        end else if (low_cnt_r == LOWV) begin
            low_cnt_r <= '0;
            low_tick <= 1'b1;
        end else begin
            low_cnt_r <= low_cnt_r + 1'b1;
            low_tick <= 1'b0;
        end
    end
endmodule

//--- tb/self_wake_down_counter_test.sv
// Purpose: self-checking bench for the self-wake down counter
// Assumes: 100 MHz clk; timer ticks derived inside the design from clk and the pin
// Notes: tick phase is unknown at load, so timeouts are checked inside windows
module self_wake_down_counter_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic pin = 1'b0;
    logic [31:0] rdata;
    logic irq;
    logic wake_req;
    int n_errors = 0;
    int checks = 0;

    always #5 clk = ~clk;

    swkt_top DUT (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr_en(wr_en),
        .rd_en(rd_en), .rdata(rdata), .wake_clock_input_pin(pin), .irq(irq),
        .wake_req(wake_req));

    task automatic close_out;
        if (n_errors == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask

    // read data only stand in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        chk(rdata, exp, what);
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // bounded wait; the limit running out shows up as a mismatch in the caller
    task automatic wait_wake(input int max);
        int n;
        n = 0;
        while (wake_req !== 1'b1 && n < max) begin
            @(posedge clk);
            #1;
            n++;
        end
    endtask

    task automatic pulse_pin(input int k);
        repeat (k) begin
            repeat (10) @(posedge clk);
            pin <= 1'b1;
            repeat (10) @(posedge clk);
            pin <= 1'b0;
        end
    endtask

    task automatic t_reset;
        chk({30'h0, irq, wake_req}, 32'h0, "outputs after reset");
        rd(swkt_pkg::OFF_CTRL, 32'h0, "ctrl reset");
        rd(swkt_pkg::OFF_COUNT, 32'h0, "count reset");
        rd(swkt_pkg::OFF_STATUS, 32'h0, "status reset");
        rd(swkt_pkg::OFF_MASK, 32'h0, "mask reset");
        wr(8'h04, 32'hffff_ffff);
        rd(8'h04, 32'h0, "unmapped read");
        rd(swkt_pkg::OFF_CTRL, 32'h0, "ctrl after unmapped write");
    endtask

    task automatic t_low;
        wr(swkt_pkg::OFF_MASK, 32'h1);
        // the low-power oscillator counts as enabled before it is picked
        wr(swkt_pkg::OFF_CTRL, 32'h1);
        wr(swkt_pkg::OFF_COUNT, 32'h3);
        idle(195);
        chk({31'h0, wake_req}, 32'h0, "low source timed out early");
        wait_wake(120);
        chk({31'h0, wake_req}, 32'h1, "low source timeout missing");
        rd(swkt_pkg::OFF_CTRL, 32'h3, "flag set at timeout");
        chk({31'h0, irq}, 32'h1, "irq with unmasked timeout");
        rd(swkt_pkg::OFF_STATUS, 32'h1, "status timeout");
        rd(swkt_pkg::OFF_STATUS, 32'h0, "status clear on read");
        idle(2);
        chk({31'h0, irq}, 32'h0, "irq after status read");
        idle(250);
        rd(swkt_pkg::OFF_COUNT, 32'h0, "counter stays off at zero");
        rd(swkt_pkg::OFF_STATUS, 32'h0, "no second timeout");
        wr(swkt_pkg::OFF_CTRL, 32'h1);
        rd(swkt_pkg::OFF_CTRL, 32'h3, "flag kept on write 0");
        wr(swkt_pkg::OFF_CTRL, 32'h3);
        rd(swkt_pkg::OFF_CTRL, 32'h1, "flag cleared by write 1");
        idle(2);
        chk({31'h0, wake_req}, 32'h0, "wake request follows flag");
    endtask

    task automatic t_fast;
        // fast source only while awake: no sleep is entered in this run
        wr(swkt_pkg::OFF_CTRL, 32'h0);
        wr(swkt_pkg::OFF_COUNT, 32'h3);
        idle(260);
        chk({31'h0, wake_req}, 32'h0, "fast source timed out early");
        wait_wake(160);
        chk({31'h0, wake_req}, 32'h1, "fast source timeout missing");
        rd(swkt_pkg::OFF_STATUS, 32'h1, "status after fast timeout");
        wr(swkt_pkg::OFF_CTRL, 32'h2);
    endtask

    // internal select set too: it must be ignored while the pin clocks the counter
    task automatic t_ext;
        wr(swkt_pkg::OFF_CTRL, 32'h9);
        wr(swkt_pkg::OFF_COUNT, 32'ha);
        pulse_pin(4);
        idle(10);
        rd(swkt_pkg::OFF_COUNT, 32'h6, "count after pin edges");
        rd(swkt_pkg::OFF_COUNT, 32'h6, "count second read");
        idle(300);
        rd(swkt_pkg::OFF_COUNT, 32'h6, "no internal ticks with pin selected");
        wr(swkt_pkg::OFF_COUNT, 32'h14);
        rd(swkt_pkg::OFF_STATUS, 32'h2, "write while running flagged");
        rd(swkt_pkg::OFF_COUNT, 32'h14, "reload value");
        wr(swkt_pkg::OFF_CTRL, 32'hc);
        rd(swkt_pkg::OFF_COUNT, 32'h0, "counter cleared");
        rd(swkt_pkg::OFF_CTRL, 32'h8, "clear bit reads zero");
        pulse_pin(2);
        idle(10);
        rd(swkt_pkg::OFF_COUNT, 32'h0, "halted after clear");
        chk({31'h0, wake_req}, 32'h0, "no timeout after clear");
    endtask

    task automatic t_masked;
        wr(swkt_pkg::OFF_MASK, 32'h0);
        wr(swkt_pkg::OFF_COUNT, 32'h1);
        pulse_pin(1);
        wait_wake(20);
        chk({31'h0, wake_req}, 32'h1, "wake request with interrupt masked");
        chk({31'h0, irq}, 32'h0, "irq masked");
        rd(swkt_pkg::OFF_STATUS, 32'h1, "status set while masked");
        wr(swkt_pkg::OFF_CTRL, 32'ha);
        rd(swkt_pkg::OFF_CTRL, 32'h8, "flag cleared, ext kept");
    endtask

    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        idle(1);
        t_reset();
        t_low();
        t_fast();
        t_ext();
        t_masked();
        close_out();
    end

    // the sequence needs about 1500 cycles
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        $display("[FAIL] %0t watchdog expired", $time);
        close_out();
    end
endmodule
